//--- logic/download_request.v
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "download_request_consts.vh"
module download_request #(
   parameter WORDS = `DLR_ROUTINE_WORDS,
   parameter AW = 16
) (
   input wire clk,
   input wire rst_n,
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire fetch_from_ram,
   output wire ram_we,
   output wire [AW-1:0] ram_addr,
   output wire [31:0] ram_wdata,
   output wire copy_busy
);
   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   // Register selects produced by the address decoder.
   localparam [2:0] SEL_NONE = 3'h0;
   localparam [2:0] SEL_CTRL = 3'h1;
   localparam [2:0] SEL_PROG = 3'h2;
   localparam [2:0] SEL_ERASE = 3'h3;
   localparam [2:0] SEL_KEY = 3'h4;
   localparam [2:0] SEL_TARGET = 3'h5;
   localparam [2:0] SEL_EMU = 3'h6;
   localparam [2:0] SEL_COUNT = 3'h7;
   reg wr_pend_r;
   reg [11:0] addr_r;
   reg req_r;
   reg req_nxt;
   reg prog_sel_r;
   reg prog_sel_nxt;
   reg erase_sel_r;
   reg erase_sel_nxt;
   reg [7:0] key_r;
   reg [7:0] key_nxt;
   reg [7:0] tdar_r;
   reg [7:0] tdar_nxt;
   reg emu_sel_r;
   reg emu_sel_nxt;
   reg [15:0] copied_r;
   reg [15:0] copied_nxt;
   reg [31:0] rd_word;
   wire [2:0] wr_sel;
   wire [2:0] rd_sel;
   wire rd_take;
   wire key_ok;
   wire fetch_ok;
   wire emu_off;
   wire req_ok;
   wire done;
   wire busy;
   wire we;
   wire start;

   // One decoder serves the write path and the read path, so the two can
   // never disagree about which register an address reaches.
   function [2:0] reg_select;
      input [11:0] a;
      begin
         if (a == `DLR_CCS_ADDR)
            reg_select = SEL_CTRL;
         else if (a == `DLR_PCS_ADDR)
            reg_select = SEL_PROG;
         else if (a == `DLR_ECS_ADDR)
            reg_select = SEL_ERASE;
         else if (a == `DLR_KEY_ADDR)
            reg_select = SEL_KEY;
         else if (a == `DLR_TDAR_ADDR)
            reg_select = SEL_TARGET;
         else if (a == `DLR_EMU_CTRL_ADDR)
            reg_select = SEL_EMU;
         else if (a == `DLR_COPIED_ADDR)
            reg_select = SEL_COUNT;
         else
            reg_select = SEL_NONE;
      end
   endfunction

   // Stalling writes (not reads) while a copy runs keeps the four no-operation window safe.
   assign hreadyout = !(wr_pend_r && busy);
   assign hresp = 1'b0;
   assign we = wr_pend_r && !busy;
   assign start = req_r && !busy;

   always @(posedge clk) begin
      if (!rst_n) begin
         wr_pend_r <= 1'b0;
         addr_r <= 12'h000;
      end else if (hreadyout) begin
         wr_pend_r <= hsel && hready && htrans[1] && hwrite;
         addr_r <= haddr;
      end
   end

   // ---------------------------------------------------------------
   // Registers and request control
   // ---------------------------------------------------------------
   assign wr_sel = reg_select(addr_r);
   assign rd_sel = reg_select(haddr);
   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   assign key_ok = (key_r == `DLR_KEY_DOWNLOAD);
   assign fetch_ok = fetch_from_ram;
   assign emu_off = !emu_sel_r;
   assign req_ok = key_ok && fetch_ok && emu_off;

   // Hardware clears come first and a software write last, so a write that
   // lands in the cycle of a clear is not lost.
   always @* begin
      req_nxt = req_r;
      prog_sel_nxt = prog_sel_r;
      erase_sel_nxt = erase_sel_r;
      key_nxt = key_r;
      tdar_nxt = tdar_r;
      emu_sel_nxt = emu_sel_r;
      copied_nxt = copied_r;
      if (start)
         req_nxt = 1'b0;
      if (done) begin
         prog_sel_nxt = 1'b0;
         erase_sel_nxt = 1'b0;
         copied_nxt = copied_r + 16'h0001;
      end
      if (we) begin
         if (wr_sel == SEL_CTRL) begin
            // A write that fails any condition is dropped.
            if (hwdata[`DLR_REQ_BIT] && req_ok)
               req_nxt = 1'b1;
         end else if (wr_sel == SEL_PROG) begin
            prog_sel_nxt = hwdata[`DLR_SEL_BIT];
         end else if (wr_sel == SEL_ERASE) begin
            erase_sel_nxt = hwdata[`DLR_SEL_BIT];
         end else if (wr_sel == SEL_KEY) begin
            key_nxt = hwdata[7:0];
         end else if (wr_sel == SEL_TARGET) begin
            tdar_nxt = hwdata[7:0];
         end else if (wr_sel == SEL_EMU) begin
            emu_sel_nxt = hwdata[`DLR_EMU_SEL_BIT];
         end
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         req_r <= 1'b0;
         prog_sel_r <= 1'b0;
         erase_sel_r <= 1'b0;
         key_r <= `DLR_KEY_RESET;
         tdar_r <= `DLR_TDAR_RESET;
         emu_sel_r <= 1'b0;
         copied_r <= 16'h0000;
      end else begin
         req_r <= req_nxt;
         prog_sel_r <= prog_sel_nxt;
         erase_sel_r <= erase_sel_nxt;
         key_r <= key_nxt;
         tdar_r <= tdar_nxt;
         emu_sel_r <= emu_sel_nxt;
         copied_r <= copied_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   // The read word is taken from the next-state values: a read whose
   // address phase meets the data phase of a write sees what that write
   // leaves behind, not the stale value. The request bit reads 0.
   always @* begin
      rd_word = 32'h00000000;
      if (rd_sel == SEL_CTRL)
         rd_word = {24'h000000, `DLR_CCS_RESET};
      else if (rd_sel == SEL_PROG)
         rd_word = {31'h0000000, prog_sel_nxt};
      else if (rd_sel == SEL_ERASE)
         rd_word = {31'h0000000, erase_sel_nxt};
      else if (rd_sel == SEL_KEY)
         rd_word = {24'h000000, key_nxt};
      else if (rd_sel == SEL_TARGET)
         rd_word = {24'h000000, tdar_nxt};
      else if (rd_sel == SEL_EMU)
         rd_word = {28'h0000000, emu_sel_nxt, 3'h0};
      else if (rd_sel == SEL_COUNT)
         rd_word = {16'h0000, copied_nxt};
   end

   // Read data is registered at the address phase and stands through the
   // data phase; any other accepted cycle returns zero.
   always @(posedge clk) begin
      if (!rst_n)
         hrdata <= 32'h00000000;
      else if (hreadyout)
         hrdata <= rd_take ? rd_word : 32'h00000000;
   end

   // ---------------------------------------------------------------
   // Copy engine
   // ---------------------------------------------------------------
   routine_copier #(.WORDS(WORDS), .AW(AW)) copier (
      .clk(clk),
      .rst_n(rst_n),
      .start(start),
      .sel_erase(erase_sel_r && !prog_sel_r),
      .base_addr({tdar_r, {(AW-8){1'b0}}}),
      .ram_we(ram_we),
      .ram_addr(ram_addr),
      .ram_wdata(ram_wdata),
      .busy(busy),
      .done(done)
   );
   assign copy_busy = busy;
endmodule // download_request
`default_nettype wire

//--- logic/download_request_consts.vh
`ifndef DOWNLOAD_REQUEST_CONSTS_VH
`define DOWNLOAD_REQUEST_CONSTS_VH
// Register byte addresses.
`define DLR_CCS_ADDR 12'h000
`define DLR_PCS_ADDR 12'h004
`define DLR_ECS_ADDR 12'h008
`define DLR_KEY_ADDR 12'h00C
`define DLR_TDAR_ADDR 12'h010
`define DLR_EMU_CTRL_ADDR 12'h014
`define DLR_COPIED_ADDR 12'h018
// Field positions.
`define DLR_REQ_BIT 0
`define DLR_ERR_BIT 4
`define DLR_RSV1_BIT 7
`define DLR_SEL_BIT 0
`define DLR_EMU_SEL_BIT 3
// Reset values and key.
`define DLR_CCS_RESET 8'h80
`define DLR_KEY_RESET 8'h00
`define DLR_KEY_DOWNLOAD 8'hA5
`define DLR_TDAR_RESET 8'h00
// Words in each built-in routine.
`define DLR_ROUTINE_WORDS 16
`endif

//--- logic/routine_copier.v
`timescale 1ns/1ps
`default_nettype none
// Copies a built-in routine, one word per cycle, into on-chip RAM.
module routine_copier #(
   parameter WORDS = 16,
   parameter AW = 16
) (
   input wire clk,
   input wire rst_n,
   input wire start,
   input wire sel_erase,
   input wire [AW-1:0] base_addr,
   output reg ram_we,
   output reg [AW-1:0] ram_addr,
   output reg [31:0] ram_wdata,
   output wire busy,
   output reg done
);
   reg [7:0] cnt_r;
   reg run_r;
   reg erase_r;
   reg [AW-1:0] base_r;
   assign busy = run_r;

   // Stand-in contents: the routine body would be a ROM in a real chip.
   function [31:0] rom_word;
      input er;
      input [7:0] idx;
      begin
         rom_word = {er ? 8'hE0 : 8'hD0, 16'h0000, idx};
      end
   endfunction

   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
         run_r <= 1'b0;
         erase_r <= 1'b0;
         base_r <= {AW{1'b0}};
         ram_we <= 1'b0;
         ram_addr <= {AW{1'b0}};
         ram_wdata <= 32'h00000000;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         ram_we <= 1'b0;
         if (start && !run_r) begin
            run_r <= 1'b1;
            erase_r <= sel_erase;
            base_r <= base_addr;
            cnt_r <= 8'h00;
         end else if (run_r) begin
            ram_we <= 1'b1;
            ram_addr <= base_r + {{(AW-8){1'b0}}, cnt_r};
            ram_wdata <= rom_word(erase_r, cnt_r);
            if (cnt_r == WORDS - 1) begin
               run_r <= 1'b0;
               done <= 1'b1;
            end
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end
endmodule // routine_copier
`default_nettype wire

//--- verif/download_request_props.sv
`timescale 1ns/1ps
`default_nettype none
module download_request_props #(parameter AW = 16) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic fetch_from_ram,
   input wire logic ram_we,
   input wire logic [AW-1:0] ram_addr,
   input wire logic [31:0] ram_wdata,
   input wire logic copy_busy
);
   logic wr_r, rd_r;
   wire acc = hsel && htrans[1] && hreadyout && haddr == 12'h000;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   always @(posedge clk) begin
      wr_r <= rst_n && acc && hwrite;
      rd_r <= rst_n && acc && !hwrite;
   end
   AST_WE_BUSY: assert property (ram_we |-> $past(copy_busy))
      else $error("ram write outside copy");
   AST_ADDR_STEP: assert property (ram_we && $past(ram_we) |->
      ram_addr == $past(ram_addr) + 1'b1) else $error("address skip");
   AST_IDX: assert property (ram_we |->
      ram_wdata[7:0] == ram_addr[7:0]) else $error("word index");
   AST_FILL: assert property (ram_we |-> ram_wdata[23:8] == 16'h0000 &&
      ram_wdata[31:24] inside {8'hD0, 8'hE0}) else $error("routine word");
   AST_FIRST: assert property ($rose(copy_busy) |=> ram_we)
      else $error("copy did not start");
   AST_END: assert property ($rose(copy_busy) |-> ##[1:40] !copy_busy)
      else $error("copy did not end");
   AST_FETCH: assert property (wr_r && hreadyout && !fetch_from_ram
      |=> !copy_busy [*3]) else $error("copy from outside ram");
   AST_CCS_READ: assert property (rd_r |-> hrdata == 32'h0000_0080)
      else $error("control read");
   cover property ($rose(copy_busy));
   cover property (wr_r && !fetch_from_ram);
   cover property (rd_r);
endmodule // download_request_props
bind download_request download_request_props #(.AW(AW)) u_props (
   .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
   .hrdata(hrdata), .fetch_from_ram(fetch_from_ram), .ram_we(ram_we),
   .ram_addr(ram_addr), .ram_wdata(ram_wdata), .copy_busy(copy_busy));
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
   $display("[ERR] %0t %h %h", $time, a, b); end end
module testbench;
   localparam int W = 8;
   logic clk = 0, rst_n = 0, hwrite = 0, fetch = 0, rd_phase = 0;
   logic [11:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic [31:0] hwdata = '0, lf = 32'hF847;
   wire hreadyout, ram_we, busy;
   wire [15:0] ram_addr;
   wire [31:0] ram_wdata, hrdata;
   logic [47:0] q[$];
   int errors = 0, cmp_count = 0;
   always #4 clk = ~clk;
   download_request #(.WORDS(W)) dut (.clk(clk), .rst_n(rst_n),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .fetch_from_ram(fetch),
      .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
      .copy_busy(busy));
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic stop_test();
      $display("Counts: %0d compares, %0d errors", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wt();
      int n = 0;
      do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 200);
      if (n >= 200) begin
         errors++;
         stop_test();
      end
   endtask
   // For a read, d is the expected data, noted for the monitor.
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wt();
      htrans <= 2'h0;
      hwdata <= d;
      if (!w) q.push_back({16'h0000, d});
      wt();
   endtask
   // Each note is popped once into e, so a mismatch report cannot take a
   // second note; an empty queue leaves a word that no result can match.
   always @(posedge clk) begin
      logic [47:0] e;
      e = '1;
      if (hreadyout === 1'b1) begin
         if (rd_phase) begin
            if (q.size() > 0) e = q.pop_front();
            `CHK({16'h0000, hrdata}, e)
         end
         rd_phase <= htrans[1] && !hwrite;
      end
      if (ram_we === 1'b1) begin
         e = '1;
         if (q.size() > 0) e = q.pop_front();
         `CHK({ram_addr, ram_wdata}, e)
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      bus(0, 12'h000, 32'h80);
      for (int i = 1; i < 5; i++) bus(0, 12'(i * 4), 32'h0);
      bus(1, 12'h020, lf);
      $display("Test reset values done");
      for (int c = 0; c < 3; c++) begin
         lf = nx(lf);
         fetch <= c != 1;
         bus(1, 12'h004, 32'h1);
         bus(1, 12'h014, c == 2 ? 32'h8 : 32'h0);
         bus(1, 12'h00C, c ? 32'hA5 : {24'h0, lf[7:0] ^ 8'h5A});
         bus(1, 12'h000, 32'h81);
         repeat (12) @(posedge clk);
         bus(0, 12'h018, 32'h0);
      end
      $display("Test refusals done");
      for (int s = 1; s < 4; s++) begin
         lf = nx(lf);
         fetch <= 1'b1;
         bus(1, 12'h014, 32'h0);
         bus(1, 12'h004, s & 1);
         bus(1, 12'h008, s >> 1);
         bus(1, 12'h010, lf[7:0]);
         bus(1, 12'h00C, 32'hA5);
         for (int i = 0; i < W; i++) q.push_back({lf[7:0], i[7:0],
            s[0] ? 8'hD0 : 8'hE0, 16'h0000, i[7:0]});
         bus(1, 12'h000, 32'h81);
         repeat (4) @(posedge clk);
         bus(1, 12'h010, lf[7:0]);
         bus(0, 12'h004, 32'h0);
         bus(0, 12'h008, 32'h0);
         bus(0, 12'h018, s);
         bus(0, 12'h000, 32'h80);
      end
      $display("Test copies done");
      stop_test();
   end
endmodule // testbench
`default_nettype wire
